// file: design/bmc_ctrl.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bmc_ctrl
   import bmc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_pending,
   input wire logic [10:0] rx_visible_bytes,
   input wire logic rx_complete,
   input wire logic rx_overrun,
   output logic upload_qualify,
   output logic upload_discard,
   input wire logic upload_seq_start,
   input wire logic upload_step_done,
   output logic upload_step_valid,
   output bmc_op_t upload_step_op,
   input wire logic download_seq_start,
   input wire logic download_indicate,
   input wire logic download_step_done,
   output logic download_step_valid,
   output bmc_op_t download_step_op,
   output logic download_enable,
   input wire logic download_busy,
   input wire logic download_polling,
   input wire logic [3:0] bus_cmd_req,
   output logic [3:0] bus_cmd,
   input wire logic target_abort_seen,
   input wire logic master_abort_seen,
   output logic timer_irq_flag,
   output logic engines_reset
);
   logic [31:0] ctrl_rw;
   logic [10:0] receive_early_threshold;
   logic upload_done_latch;
   logic download_done_flag;
   logic download_halted_flag;
   logic timer_arm_flag;
   logic target_abort_flag;
   logic master_abort_flag;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] wmask;
   logic ack_up_wr;
   logic ack_dn_wr;
   logic ack_tmr_wr;
   logic cmd_wr;
   logic cd_load;
   logic [15:0] cd_count;
   logic [15:0] free_running_timer;
   logic cd_expire;
   logic up_finish;
   logic dn_irq;
   logic blocked;
   logic up_legacy;
   logic dn_legacy;
   logic dn_ind;
   logic [31:0] status_word;
   logic [31:0] int_word;
   logic [10:0] qual_level;
   bmc_up_state_t up_state;
   bmc_dn_state_t dn_state;

   // Byte-lane mask from write strobes
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // Registers answering at an address; others get SLVERR
   function automatic logic reg_known(input logic [7:0] a);
      return a == ADDR_ACK || a == ADDR_CMD || a == ADDR_COUNTDOWN || a == ADDR_FREE ||
             a == ADDR_RX_THRESH || a == ADDR_INT_STATUS || a == ADDR_CTRL;
   endfunction

   // Download step table, indexed by step and order bit
   function automatic bmc_op_t dn_op(input bmc_dn_state_t st, input logic legacy);
      case (st)
         DN_STEP1: return legacy ? OP_WRITE_DONE : OP_FETCH_NEXT;
         DN_STEP2: return legacy ? OP_FETCH_NEXT : OP_RAISE_IRQ;
         DN_STEP3: return legacy ? OP_RAISE_IRQ : OP_WRITE_DONE;
         default: return OP_FETCH_NEXT;
      endcase
   endfunction

   // Write side: address and data taken together, one at a time
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;
   assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wmask = strb_mask(s_axi_wstrb);
   assign ack_up_wr = wr_fire && s_axi_awaddr == ADDR_ACK && s_axi_wstrb[0] && s_axi_wdata[ACK_UP];
   assign ack_dn_wr = wr_fire && s_axi_awaddr == ADDR_ACK && s_axi_wstrb[0] && s_axi_wdata[ACK_DN];
   assign ack_tmr_wr = wr_fire && s_axi_awaddr == ADDR_ACK && s_axi_wstrb[0] && s_axi_wdata[ACK_TIMER];
   assign cmd_wr = wr_fire && s_axi_awaddr == ADDR_CMD && s_axi_wstrb[0];
   // Partial countdown writes would load half a value, so both low lanes are needed
   assign cd_load = wr_fire && s_axi_awaddr == ADDR_COUNTDOWN && (&s_axi_wstrb[1:0]);

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_rw <= CTRL_RESET;
      end else if (wr_fire && s_axi_awaddr == ADDR_CTRL) begin
         ctrl_rw <= (ctrl_rw & ~(wmask & CTRL_RW_MASK)) | (s_axi_wdata & wmask & CTRL_RW_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_early_threshold <= THRESH_RESET;
      end else if (wr_fire && s_axi_awaddr == ADDR_RX_THRESH) begin
         receive_early_threshold <= (receive_early_threshold & ~wmask[10:0]) | (s_axi_wdata[10:0] & wmask[10:0]);
      end
   end

   // sticky upload flag, set wins over acknowledge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upload_done_latch <= 1'b0;
      end else if (up_finish) begin
         upload_done_latch <= 1'b1;
      end else if (ack_up_wr) begin
         upload_done_latch <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         download_done_flag <= 1'b0;
      end else if (dn_irq) begin
         download_done_flag <= 1'b1;
      end else if (ack_dn_wr) begin
         download_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         download_halted_flag <= 1'b0;
      end else if (cmd_wr && s_axi_wdata[CMD_HALT]) begin
         download_halted_flag <= 1'b1;
      end else if (cmd_wr && s_axi_wdata[CMD_RESUME]) begin
         download_halted_flag <= 1'b0;
      end
   end

   // abort flags, a new abort beats the clear
   // cleared by global reset with engine mask clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         target_abort_flag <= 1'b0;
         master_abort_flag <= 1'b0;
         engines_reset <= 1'b0;
      end else begin
         engines_reset <= cmd_wr && s_axi_wdata[CMD_GRESET] && !s_axi_wdata[CMD_ENG_MASK];
         if (target_abort_seen) begin
            target_abort_flag <= 1'b1;
         end else if (cmd_wr && s_axi_wdata[CMD_GRESET] && !s_axi_wdata[CMD_ENG_MASK]) begin
            target_abort_flag <= 1'b0;
         end
         if (master_abort_seen) begin
            master_abort_flag <= 1'b1;
         end else if (cmd_wr && s_axi_wdata[CMD_GRESET] && !s_axi_wdata[CMD_ENG_MASK]) begin
            master_abort_flag <= 1'b0;
         end
      end
   end

   // tick rate and start mode go to the timer
   bmc_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .rate_fast(ctrl_rw[BIT_RATE]),
      .start_mode(ctrl_rw[BIT_MODE]),
      .load(cd_load),
      .load_value(s_axi_wdata[15:0]),
      .dn_done_status(download_done_flag),
      .count(cd_count),
      .free_count(free_running_timer),
      .expire(cd_expire)
   );

   // arm flag managed by hardware only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_arm_flag <= 1'b0;
      end else if (cd_load) begin
         timer_arm_flag <= s_axi_wdata[15:0] != 16'h0000;
      end else if (cd_expire && timer_arm_flag) begin
         timer_arm_flag <= 1'b0;
      end
   end

   // expiry sets request only while armed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_irq_flag <= 1'b0;
      end else if (cd_expire && timer_arm_flag) begin
         timer_irq_flag <= 1'b1;
      end else if (ack_tmr_wr) begin
         timer_irq_flag <= 1'b0;
      end
   end

   assign status_word = ctrl_rw | (32'(download_halted_flag) << BIT_HALTED) |
                        (32'(upload_done_latch) << BIT_UP_DONE) | (32'(download_done_flag) << BIT_DN_DONE) |
                        (32'(timer_arm_flag) << BIT_ARM) |
                        (32'(download_busy || download_polling || dn_state != DN_IDLE) << BIT_ACTIVE) |
                        (32'(target_abort_flag) << BIT_TABORT) | (32'(master_abort_flag) << BIT_MABORT);
   assign int_word = (32'(upload_done_latch) << BIT_UP_DONE) | (32'(download_done_flag) << BIT_DN_DONE) |
                     (32'(timer_irq_flag) << INT_TIMER);

   // Read data registered; command registers read zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_COUNTDOWN: s_axi_rdata <= {16'h0000, cd_count};
            ADDR_FREE: s_axi_rdata <= {16'h0000, free_running_timer};
            ADDR_RX_THRESH: s_axi_rdata <= {21'h000000, receive_early_threshold};
            ADDR_INT_STATUS: s_axi_rdata <= int_word;
            ADDR_CTRL: s_axi_rdata <= status_word;
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // engines blocked while any abort stands
   assign blocked = target_abort_flag || master_abort_flag;
   assign download_enable = !blocked && !download_halted_flag;

   // visibility point is the threshold with the early bit set, else the smaller of 60 and the threshold
   assign qual_level = ctrl_rw[BIT_EARLY] ? receive_early_threshold :
                       (receive_early_threshold < VISIBLE_BYTES ? receive_early_threshold : VISIBLE_BYTES);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upload_qualify <= 1'b0;
         upload_discard <= 1'b0;
      end else begin
         upload_discard <= rx_pending && rx_overrun && !ctrl_rw[BIT_KEEP_OVR];
         upload_qualify <= rx_pending && !blocked && !(rx_overrun && !ctrl_rw[BIT_KEEP_OVR]) &&
                           (rx_complete || rx_visible_bytes >= qual_level);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_cmd <= PCI_MEM_READ;
      end else if (bus_cmd_req == PCI_MEM_WRITE_INV && ctrl_rw[BIT_NO_MWI]) begin
         bus_cmd <= PCI_MEM_WRITE;
      end else if (bus_cmd_req == PCI_MEM_READ_LINE && ctrl_rw[BIT_NO_MRL]) begin
         bus_cmd <= PCI_MEM_READ;
      end else begin
         bus_cmd <= bus_cmd_req;
      end
   end

   // upload descriptor sequencer; order latched at start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_state <= UP_IDLE;
         up_legacy <= 1'b0;
         up_finish <= 1'b0;
      end else begin
         up_finish <= 1'b0;
         case (up_state)
            UP_IDLE: begin
               if (upload_seq_start && !blocked) begin
                  up_legacy <= ctrl_rw[BIT_UP_LEGACY];
                  up_state <= UP_FIRST;
               end
            end
            UP_FIRST: begin
               if (upload_step_done) begin
                  up_state <= UP_SECOND;
               end
            end
            UP_SECOND: begin
               if (upload_step_done) begin
                  up_state <= UP_IDLE;
                  up_finish <= 1'b1;
               end
            end
            default: up_state <= UP_IDLE;
         endcase
      end
   end
   assign upload_step_valid = up_state != UP_IDLE;
   assign upload_step_op = ((up_state == UP_FIRST) == up_legacy) ? OP_WRITE_STATUS : OP_FETCH_NEXT;

   // download sequencer; irq step is internal and takes one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dn_state <= DN_IDLE;
         dn_legacy <= 1'b0;
         dn_ind <= 1'b0;
         dn_irq <= 1'b0;
      end else begin
         dn_irq <= 1'b0;
         case (dn_state)
            DN_IDLE: begin
               if (download_seq_start && download_enable) begin
                  dn_legacy <= ctrl_rw[BIT_DN_LEGACY];
                  dn_ind <= download_indicate;
                  dn_state <= DN_STEP1;
               end
            end
            DN_STEP1, DN_STEP2, DN_STEP3: begin
               if (dn_op(dn_state, dn_legacy) == OP_RAISE_IRQ || download_step_done) begin
                  dn_irq <= dn_op(dn_state, dn_legacy) == OP_RAISE_IRQ && dn_ind;
                  dn_state <= dn_state == DN_STEP3 ? DN_IDLE : (dn_state == DN_STEP1 ? DN_STEP2 : DN_STEP3);
               end
            end
            default: dn_state <= DN_IDLE;
         endcase
      end
   end
   assign download_step_op = dn_op(dn_state, dn_legacy);
   assign download_step_valid = dn_state != DN_IDLE && download_step_op != OP_RAISE_IRQ;

   up_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      upload_done_latch && !ack_up_wr |=> upload_done_latch) else $error("upload flag dropped");
   up_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ack_up_wr && !up_finish |=> !upload_done_latch) else $error("upload flag not cleared");
   dn_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dn_irq |=> download_done_flag && status_word[BIT_DN_DONE]) else $error("download flag missing");
   timer_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cd_expire && !timer_arm_flag && !ack_tmr_wr |=> timer_irq_flag == $past(timer_irq_flag))
      else $error("unarmed expiry changed request");
   arm_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cd_load && s_axi_wdata[15:0] != 16'h0000 |=> timer_arm_flag)
      else $error("arm not set");
   early_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_rw[BIT_EARLY] && !rx_complete && rx_visible_bytes < receive_early_threshold |=> !upload_qualify)
      else $error("early upload started");
   abort_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      blocked |-> !download_enable ##1 !upload_qualify) else $error("engines not blocked");
   mwi_defeat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_rw[BIT_NO_MWI] |=> bus_cmd != PCI_MEM_WRITE_INV) else $error("write invalidate issued");
   mrl_defeat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_rw[BIT_NO_MRL] |=> bus_cmd != PCI_MEM_READ_LINE) else $error("read line issued");
   up_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      up_state == UP_FIRST && !up_legacy |-> upload_step_op == OP_FETCH_NEXT) else $error("upload order wrong");
   halt_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_wr && s_axi_wdata[CMD_HALT] |=> download_halted_flag && !download_enable) else $error("halt not shown");
endmodule // bmc_ctrl

// file: design/bmc_pkg.sv
package bmc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_ACK = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_COUNTDOWN = 8'h08;
   localparam logic [7:0] ADDR_FREE = 8'h0C;
   localparam logic [7:0] ADDR_RX_THRESH = 8'h10;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CTRL = 8'h20;

   // Control and status bit positions
   localparam int BIT_HALTED = 2;
   localparam int BIT_UP_DONE = 3;
   localparam int BIT_DN_DONE = 4;
   localparam int BIT_EARLY = 5;
   localparam int BIT_ARM = 6;
   localparam int BIT_ACTIVE = 7;
   localparam int BIT_RATE = 8;
   localparam int BIT_MODE = 9;
   localparam int BIT_UP_LEGACY = 16;
   localparam int BIT_DN_LEGACY = 17;
   localparam int BIT_NO_MWI = 20;
   localparam int BIT_NO_MRL = 21;
   localparam int BIT_KEEP_OVR = 22;
   localparam int BIT_TABORT = 30;
   localparam int BIT_MABORT = 31;
   localparam logic [31:0] CTRL_RW_MASK = 32'h0073_0320;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Acknowledge register bits (written as one command)
   localparam int ACK_UP = 0;
   localparam int ACK_DN = 1;
   localparam int ACK_TIMER = 2;
   // Command register bits
   localparam int CMD_HALT = 0;
   localparam int CMD_RESUME = 1;
   localparam int CMD_GRESET = 2;
   localparam int CMD_ENG_MASK = 3;
   // Interrupt status bit of the timer request
   localparam int INT_TIMER = 6;

   // Receive threshold and visibility
   localparam int THRESH_W = 11;
   localparam logic [10:0] VISIBLE_BYTES = 11'h03C;
   localparam logic [10:0] THRESH_RESET = 11'h7FF;
   localparam int TIMER_W = 16;

   // Timer tick periods
   localparam int CLK_PERIOD_PS = 10000;
   localparam int SLOW_TICK_PS = 3200000;
   localparam int FAST_TICK_PS = 320000;
   localparam int SLOW_TICK_CYC = (SLOW_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FAST_TICK_CYC = (FAST_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // PCI bus commands
   localparam logic [3:0] PCI_MEM_READ = 4'h6;
   localparam logic [3:0] PCI_MEM_WRITE = 4'h7;
   localparam logic [3:0] PCI_MEM_READ_LINE = 4'hE;
   localparam logic [3:0] PCI_MEM_WRITE_INV = 4'hF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {OP_FETCH_NEXT, OP_WRITE_STATUS, OP_WRITE_DONE, OP_RAISE_IRQ} bmc_op_t;
   typedef enum logic [1:0] {UP_IDLE, UP_FIRST, UP_SECOND} bmc_up_state_t;
   typedef enum logic [1:0] {DN_IDLE, DN_STEP1, DN_STEP2, DN_STEP3} bmc_dn_state_t;
endpackage

// file: design/bmc_timer.sv
`timescale 1ns/1ps
module bmc_timer
   import bmc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rate_fast,
   input wire logic start_mode,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic dn_done_status,
   output logic [15:0] count,
   output logic [15:0] free_count,
   output logic expire
);
   logic [8:0] presc;
   logic tick;
   logic running;
   logic waiting;

   // Tick period chosen by the rate bit; compare at or past the end so a rate change never wraps the divider
   assign tick = presc >= (rate_fast ? 9'(FAST_TICK_CYC - 1) : 9'(SLOW_TICK_CYC - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         presc <= 9'h000;
      end else begin
         presc <= presc + 9'h001;
      end
   end

   // Free-running timer, same tick as countdown
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         free_count <= 16'h0000;
      end else if (tick) begin
         free_count <= free_count + 16'h0001;
      end
   end

   // Countdown: delayed start waits on download-complete status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= 16'h0000;
         running <= 1'b0;
         waiting <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (load) begin
            count <= load_value;
            running <= (load_value != 16'h0000) && !start_mode;
            waiting <= (load_value != 16'h0000) && start_mode;
         end else if (waiting) begin
            if (dn_done_status) begin
               waiting <= 1'b0;
               running <= 1'b1;
            end
         end else if (running && tick) begin
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
               running <= 1'b0;
               expire <= 1'b1;
            end
         end
      end
   end
endmodule // bmc_timer

// file: bench/bmc_engine_model.sv
`timescale 1ns/1ps
// Far-side engine: ends each step after LAT idle cycles
module bmc_engine_model #(parameter int LAT = 0) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic step_valid,
   output logic step_done
);
   int cnt;
   // One-cycle done pulse; the pulse cycle itself never counts toward the next step
   always_ff @(posedge aclk) begin
      step_done <= aresetn && step_valid && !step_done && cnt >= LAT;
      cnt <= (!aresetn || !step_valid || step_done || cnt >= LAT) ? 0 : cnt + 1;
   end
endmodule // bmc_engine_model

// file: bench/bmc_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module bmc_ctrl_bench;
   import bmc_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_pending, upload_seq_start;
   logic upload_step_done, upload_step_valid, download_seq_start, download_indicate, download_step_done;
   logic download_step_valid, download_enable, download_polling, target_abort_seen, master_abort_seen;
   logic timer_irq_flag, rx_complete, rx_overrun, upload_qualify, upload_discard, engines_reset;
   logic [10:0] rx_visible_bytes;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] bus_cmd_req, bus_cmd;
   logic [1:0] s_axi_bresp;
   bmc_op_t upload_step_op, download_step_op, upq[$], dnq[$];
   int mismatches = 0, n_checks = 0, cyc = 0, n_rst = 0, r, ex;
   bmc_ctrl i_bmc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid,
      .s_axi_rready, .rx_pending, .rx_visible_bytes, .rx_complete, .rx_overrun,
      .upload_qualify, .upload_discard, .upload_seq_start, .upload_step_done, .upload_step_valid,
      .upload_step_op, .download_seq_start, .download_indicate, .download_step_done, .download_step_valid,
      .download_step_op, .download_enable, .download_busy(1'b0), .download_polling, .bus_cmd_req,
      .bus_cmd, .target_abort_seen, .master_abort_seen, .timer_irq_flag, .engines_reset);
   bmc_engine_model i_up (.aclk, .aresetn, .step_valid(upload_step_valid), .step_done(upload_step_done));
   bmc_engine_model #(.LAT(4)) i_dn (.aclk, .aresetn, .step_valid(download_step_valid),
      .step_done(download_step_done));
   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Step log for order checks; cycle ceiling cuts a hang short
   always @(posedge aclk) begin
      cyc++;
      if (upload_step_valid && upload_step_done) upq.push_back(upload_step_op);
      if (download_step_valid && download_step_done) dnq.push_back(download_step_op);
      if (engines_reset === 1'b1) n_rst++;
      if (cyc == 6000) begin
         mismatches++;
         results();
      end
   end
   // Write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      @(posedge aclk);
   endtask
   // Read compared with the model word
   task automatic rd(input logic [7:0] a, input int e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, e)
      @(posedge aclk);
   endtask
   // One-cycle pulse: upload start, download start, target abort, master abort
   task automatic kick(input logic [3:0] p);
      {upload_seq_start, download_seq_start, target_abort_seen, master_abort_seen} <= p;
      @(posedge aclk);
      {upload_seq_start, download_seq_start, target_abort_seen, master_abort_seen} <= 4'h0;
      @(posedge aclk);
   endtask
   // Closing report
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_pending} = '0;
      {upload_seq_start, download_seq_start, download_polling, target_abort_seen, master_abort_seen} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, bus_cmd_req, rx_visible_bytes, rx_complete, rx_overrun} = '0;
      download_indicate = 1'b1;
      r = $urandom(32'h3A5A);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      // reset value, only control bits writable
      rd(ADDR_CTRL, 0);
      repeat (4) begin
         r = $urandom();
         wr(ADDR_CTRL, r);
         rd(ADDR_CTRL, r & CTRL_RW_MASK);
      end
      wr(8'h40, 0, RESP_SLVERR);
      // command substitution for every bit pair
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, k << 20);
         bus_cmd_req <= PCI_MEM_WRITE_INV;
         repeat (2) @(posedge aclk);
         `CHK(bus_cmd, k[0] ? PCI_MEM_WRITE : PCI_MEM_WRITE_INV)
         bus_cmd_req <= PCI_MEM_READ_LINE;
         repeat (2) @(posedge aclk);
         `CHK(bus_cmd, k[1] ? PCI_MEM_READ : PCI_MEM_READ_LINE)
      end
      wr(ADDR_CTRL, 32'h100);
      wr(ADDR_COUNTDOWN, 3);
      rd(ADDR_CTRL, 32'h140);
      repeat (5 * FAST_TICK_CYC) @(posedge aclk);
      `CHK(timer_irq_flag, 1'b1)
      rd(ADDR_CTRL, 32'h100);
      // step order in both modes, done flags
      for (int lg = 0; lg < 2; lg++) begin
         ex = 32'h300 | lg * 32'h30000;
         wr(ADDR_CTRL, ex);
         wr(ADDR_ACK, 4);
         wr(ADDR_COUNTDOWN, 1);
         repeat (40) @(posedge aclk);
         `CHK(timer_irq_flag, 1'b0)
         upq.delete();
         dnq.delete();
         kick(4'hC);
         for (int t = 0; t < 80 && (upq.size() < 2 || dnq.size() < 2); t++) @(posedge aclk);
         repeat (50) @(posedge aclk);
         `CHK(timer_irq_flag, 1'b1)
         `CHK(upq[0], lg ? OP_WRITE_STATUS : OP_FETCH_NEXT)
         `CHK({dnq[0], dnq[1]}, lg ? {OP_WRITE_DONE, OP_FETCH_NEXT} : {OP_FETCH_NEXT, OP_WRITE_DONE})
         rd(ADDR_CTRL, ex | 32'h18);
         wr(ADDR_ACK, 3);
         rd(ADDR_CTRL, ex);
      end
      // qualification and discard against random levels
      for (int k = 0; k < 16; k++) begin
         r = $urandom % 128;
         ex = $urandom % 128;
         wr(ADDR_RX_THRESH, r);
         wr(ADDR_CTRL, (k & 1) * 32'h20 | (k & 4) * 32'h100000);
         {rx_pending, rx_overrun, rx_complete, rx_visible_bytes} <= {1'b1, k[1], k[3], 11'(ex)};
         repeat (2) @(posedge aclk);
         `CHK(upload_discard, k[1] && !k[2])
         `CHK(upload_qualify, !(k[1] && !k[2]) && (k[3] || ex >= ((k & 1) ? r : (r < 60 ? r : 60))))
      end
      // aborts block engines until unmasked global reset
      wr(ADDR_CTRL, 0);
      kick(4'h3);
      rd(ADDR_CTRL, 32'hC0000000);
      kick(4'h8);
      `CHK({download_enable, upload_step_valid}, 2'h0)
      wr(ADDR_CMD, 32'hC);
      rd(ADDR_CTRL, 32'hC0000000);
      wr(ADDR_CMD, 32'h4);
      `CHK(n_rst, 1)
      rd(ADDR_CTRL, 0);
      wr(ADDR_CMD, 1);
      download_polling <= 1'b1;
      rd(ADDR_CTRL, 32'h84);
      // driver halts, then waits for inactive
      download_polling <= 1'b0;
      rd(ADDR_CTRL, 32'h4);
      download_polling <= 1'b1;
      wr(ADDR_CMD, 2);
      rd(ADDR_CTRL, 32'h80);
      results();
   end
endmodule // bmc_ctrl_bench
